// [design/mcuad_params.svh]
/*
 * Constants of the execute-stage datapath: offsets, reset values, counts.
 * Assumes it is included by bare name from the core.
 */
`ifndef MCUAD_PARAMS_SVH
`define MCUAD_PARAMS_SVH
// system clocks in one instruction cycle
`define MCUAD_CLK_PER_ICYC 4
// sector-0 offset of the program counter low byte
`define MCUAD_PC_LOW_ADDR 8'h06
// reset values
`define MCUAD_WREG_RST 8'h00
`define MCUAD_FLAG_RST 1'b0
// decimal adjust constants
`define MCUAD_BCD_DIGIT_MAX 4'h9
`define MCUAD_BCD_LOW_FIX 9'h006
`define MCUAD_BCD_HIGH_FIX 9'h060
`endif

// [design/mcuad_pkg.sv]
/*
 * Types of the execute-stage datapath: the operation codes.
 * Assumes the sequencer decodes opcodes into these values.
 */
package mcuad_pkg;
	typedef enum logic [5:0] {
		OP_NOP, OP_ADD_M, OP_ADD_X, OP_ADD_TO_MEM, OP_ADC_M, OP_ADC_TO_MEM,
		OP_SUB_X, OP_SUB_M, OP_SUB_TO_MEM, OP_SUBB_X, OP_SUBB_M,
		OP_SUBB_TO_MEM, OP_DEC_ADJ, OP_AND_M, OP_OR_M, OP_XOR_M,
		OP_AND_TO_MEM, OP_OR_TO_MEM, OP_XOR_TO_MEM, OP_AND_X, OP_OR_X,
		OP_XOR_X, OP_INV, OP_INV_TO_REG, OP_INC, OP_INC_TO_REG, OP_DEC,
		OP_DEC_TO_REG, OP_ROR, OP_ROR_TO_REG, OP_ROL, OP_ROL_TO_REG,
		OP_RORC, OP_RORC_TO_REG, OP_ROLC, OP_ROLC_TO_REG, OP_SET_BIT,
		OP_CLR_BIT, OP_SKIP_ZERO, OP_SKIP_NZ, OP_SKIP_BIT_Z, OP_SKIP_BIT_NZ,
		OP_JUMP, OP_CALL, OP_RET
	} mcuad_op_t;
endpackage

// [design/mcuad_core.sv]
/*
 * Execute stage of an 8-bit core: arithmetic, logic, rotate, bit, skip
 * and call/return flow. Assumes the sequencer presents one decoded
 * operation with its sector-0 memory byte already read, and performs
 * the fetch and the stack itself; the memory write comes from this stage.
 */
`timescale 1ns/10ps
`include "mcuad_params.svh"
module mcuad_core import mcuad_pkg::*; #(
	parameter int CLK_PER_ICYC = `MCUAD_CLK_PER_ICYC,
	parameter int SECTOR_W = 3
) (
	// clock and reset
	input wire logic mclk,
	input wire logic rst_b,
	// operation request from the sequencer
	input wire logic op_valid,
	input wire mcuad_op_t op_code,
	input wire logic [7:0] op_imm,
	input wire logic [2:0] op_bit,
	input wire logic [SECTOR_W-1:0] op_sector,
	input wire logic [7:0] op_addr,
	input wire logic [7:0] mem_rdata,
	input wire logic [15:0] ret_addr,
	output logic ready_r,
	output logic done_r,
	output logic err_r,
	// sector-0 memory write
	output logic mem_we_r,
	output logic [7:0] mem_addr_r,
	output logic [7:0] mem_wdata_r,
	// program flow to the sequencer
	output logic skip_r,
	output logic jump_r,
	output logic push_r,
	output logic [15:0] push_addr_r,
	output logic pop_r,
	// working register and status flags
	output logic [7:0] working_register,
	output logic zero_r,
	output logic carry_r,
	output logic nibble_carry_bit,
	output logic signed_range_error,
	output logic signed_carry_bit,
	output logic chained_null_bit
);
	localparam int CW = 8;
	generate
		if (CLK_PER_ICYC < 2 || CLK_PER_ICYC > 64) begin : g_bad_cpi
			$error("CLK_PER_ICYC must lie in 2..64");
		end
	endgenerate

	// 8-bit adder: {overflow, nibble carry, carry, sum}
	function automatic logic [10:0] add8(input logic [7:0] a,
		input logic [7:0] b, input logic cin);
		logic [8:0] s;
		logic [4:0] lo;
		s = {1'b0, a} + {1'b0, b} + {8'h00, cin};
		lo = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
		add8 = {(a[7] == b[7]) && (s[7] != a[7]), lo[4], s};
	endfunction

	// reset release through two flops
	logic rst_s1_r, rst_s2_r;
	always_ff @(posedge mclk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_r <= 1'b0;
			rst_s2_r <= 1'b0;
		end else begin
			rst_s1_r <= 1'b1;
			rst_s2_r <= rst_s1_r;
		end
	end
	wire logic rstn = rst_s2_r;

	wire logic take = op_valid && ready_r;
	logic [7:0] opnd, res;
	logic [10:0] ar;
	logic to_mem, to_reg, mem_use, skip, flow_jmp, flow_call, flow_ret;
	logic [1:0] icyc;
	logic fz, fc, fn, fo, fs, fcz;
	logic [8:0] bcd;

	// decode and compute; flags default to held values
	always_comb begin
		opnd = (op_code inside {OP_ADD_X, OP_SUB_X, OP_SUBB_X, OP_AND_X,
			OP_OR_X, OP_XOR_X}) ? op_imm : mem_rdata;
		res = mem_rdata;
		to_mem = 1'b0;
		to_reg = 1'b0;
		mem_use = 1'b1;
		skip = 1'b0;
		flow_jmp = 1'b0;
		flow_call = 1'b0;
		flow_ret = 1'b0;
		icyc = 2'd1;
		fz = zero_r;
		fc = carry_r;
		fn = nibble_carry_bit;
		fo = signed_range_error;
		fs = signed_carry_bit;
		fcz = chained_null_bit;
		bcd = 9'h000;
		// subtract is a + ~b + carry-in; carry out high means no borrow
		case (op_code)
			OP_SUB_X, OP_SUB_M, OP_SUB_TO_MEM:
				ar = add8(working_register, ~opnd, 1'b1);
			OP_SUBB_X, OP_SUBB_M, OP_SUBB_TO_MEM:
				ar = add8(working_register, ~opnd, carry_r);
			OP_ADC_M, OP_ADC_TO_MEM:
				ar = add8(working_register, opnd, carry_r);
			default:
				ar = add8(working_register, opnd, 1'b0);
		endcase
		case (op_code)
			OP_ADD_M, OP_ADD_X, OP_ADC_M, OP_ADD_TO_MEM, OP_ADC_TO_MEM,
			OP_SUB_X, OP_SUB_M, OP_SUB_TO_MEM, OP_SUBB_X, OP_SUBB_M,
			OP_SUBB_TO_MEM: begin
				res = ar[7:0];
				to_mem = op_code inside {OP_ADD_TO_MEM, OP_ADC_TO_MEM,
					OP_SUB_TO_MEM, OP_SUBB_TO_MEM};
				to_reg = !to_mem;
				fz = (ar[7:0] == 8'h00);
				fc = ar[8];
				fn = ar[9];
				fo = ar[10];
				fs = ar[10] ^ ar[7];
				if (op_code inside {OP_SUB_X, OP_SUB_M, OP_SUB_TO_MEM})
					fcz = fz;
				else if (op_code inside {OP_SUBB_X, OP_SUBB_M, OP_SUBB_TO_MEM})
					fcz = fz && chained_null_bit;
			end
			OP_DEC_ADJ: begin
				bcd = {1'b0, working_register};
				if (bcd[3:0] > `MCUAD_BCD_DIGIT_MAX || nibble_carry_bit)
					bcd = bcd + `MCUAD_BCD_LOW_FIX;
				if (bcd[7:4] > `MCUAD_BCD_DIGIT_MAX || carry_r || bcd[8])
					bcd = bcd + `MCUAD_BCD_HIGH_FIX;
				res = bcd[7:0];
				to_mem = 1'b1;
				fc = carry_r || bcd[8];
			end
			OP_AND_M, OP_AND_X, OP_AND_TO_MEM:
				res = working_register & opnd;
			OP_OR_M, OP_OR_X, OP_OR_TO_MEM:
				res = working_register | opnd;
			OP_XOR_M, OP_XOR_X, OP_XOR_TO_MEM:
				res = working_register ^ opnd;
			OP_INV, OP_INV_TO_REG: res = ~mem_rdata;
			OP_INC, OP_INC_TO_REG: res = mem_rdata + 8'h01;
			OP_DEC, OP_DEC_TO_REG: res = mem_rdata - 8'h01;
			OP_ROR, OP_ROR_TO_REG: res = {mem_rdata[0], mem_rdata[7:1]};
			OP_ROL, OP_ROL_TO_REG: res = {mem_rdata[6:0], mem_rdata[7]};
			OP_RORC, OP_RORC_TO_REG: begin
				res = {carry_r, mem_rdata[7:1]};
				fc = mem_rdata[0];
			end
			OP_ROLC, OP_ROLC_TO_REG: begin
				res = {mem_rdata[6:0], carry_r};
				fc = mem_rdata[7];
			end
			OP_SET_BIT: res = mem_rdata | (8'h01 << op_bit);
			OP_CLR_BIT: res = mem_rdata & ~(8'h01 << op_bit);
			OP_SKIP_ZERO: skip = (mem_rdata == 8'h00);
			OP_SKIP_NZ: skip = (mem_rdata != 8'h00);
			OP_SKIP_BIT_Z: skip = !mem_rdata[op_bit];
			OP_SKIP_BIT_NZ: skip = mem_rdata[op_bit];
			OP_JUMP: flow_jmp = 1'b1;
			OP_CALL: flow_call = 1'b1;
			OP_RET: flow_ret = 1'b1;
			default: mem_use = 1'b0;
		endcase
		if (op_code inside {OP_JUMP, OP_CALL, OP_RET})
			mem_use = 1'b0;
		// logic, invert, increment and decrement touch only zero
		if (op_code inside {[OP_AND_M:OP_DEC_TO_REG]}) begin
			fz = (res == 8'h00);
			to_mem = op_code inside {OP_AND_TO_MEM, OP_OR_TO_MEM,
				OP_XOR_TO_MEM, OP_INV, OP_INC, OP_DEC};
			to_reg = !to_mem;
		end
		if (op_code inside {[OP_ROR:OP_CLR_BIT]}) begin
			to_mem = op_code inside {OP_ROR, OP_ROL, OP_RORC, OP_ROLC,
				OP_SET_BIT, OP_CLR_BIT};
			to_reg = !to_mem;
		end
		if (skip || flow_jmp || flow_call || flow_ret)
			icyc = 2'd2;
		if (to_mem && op_addr == `MCUAD_PC_LOW_ADDR)
			icyc = 2'd2;
	end

	// memory operands outside sector 0 are refused
	wire logic bad_sector = mem_use && (op_sector != '0);
	wire logic go = take && !bad_sector;

	// instruction-cycle timer; ready again after icyc*CLK_PER_ICYC clocks
	logic busy_r;
	logic [7:0] left_r;
	logic [1:0] pend_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			busy_r <= 1'b0;
			ready_r <= 1'b0;
			left_r <= 8'h00;
			done_r <= 1'b0;
		end else begin
			done_r <= 1'b0;
			if (go) begin
				busy_r <= 1'b1;
				ready_r <= 1'b0;
				left_r <= 8'(int'(icyc) * CLK_PER_ICYC - 2);
			end else if (busy_r) begin
				if (left_r == 8'h00) begin
					busy_r <= 1'b0;
					ready_r <= 1'b1;
					done_r <= 1'b1;
				end else begin
					left_r <= left_r - 8'h01;
				end
			end else begin
				ready_r <= 1'b1;
			end
		end
	end

	// flow pulses held until the instruction ends
	logic skip_p_r, jump_p_r, call_p_r, ret_p_r;
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{skip_p_r, jump_p_r, call_p_r, ret_p_r} <= 4'h0;
			{skip_r, jump_r, push_r, pop_r} <= 4'h0;
			push_addr_r <= 16'h0000;
			err_r <= 1'b0;
		end else begin
			err_r <= take && bad_sector;
			{skip_r, jump_r, push_r, pop_r} <= 4'h0;
			if (go) begin
				skip_p_r <= skip;
				jump_p_r <= flow_jmp || (to_mem && icyc == 2'd2);
				call_p_r <= flow_call;
				ret_p_r <= flow_ret;
				if (flow_call)
					push_addr_r <= ret_addr;
			end else if (busy_r && left_r == 8'h00) begin
				{skip_r, jump_r, push_r, pop_r} <=
					{skip_p_r, jump_p_r || call_p_r, call_p_r, ret_p_r};
			end
		end
	end

	// result write: working register or one memory write pulse
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			working_register <= `MCUAD_WREG_RST;
			mem_we_r <= 1'b0;
			mem_addr_r <= 8'h00;
			mem_wdata_r <= 8'h00;
		end else begin
			mem_we_r <= go && to_mem;
			if (go && to_mem) begin
				mem_addr_r <= op_addr;
				mem_wdata_r <= res;
			end
			if (go && to_reg)
				working_register <= res;
		end
	end

	// status flags
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			{zero_r, carry_r, nibble_carry_bit} <= {3{`MCUAD_FLAG_RST}};
			signed_range_error <= `MCUAD_FLAG_RST;
			signed_carry_bit <= `MCUAD_FLAG_RST;
			chained_null_bit <= `MCUAD_FLAG_RST;
		end else if (go) begin
			{zero_r, carry_r, nibble_carry_bit} <= {fz, fc, fn};
			signed_range_error <= fo;
			signed_carry_bit <= fs;
			chained_null_bit <= fcz;
		end
	end

	default clocking @(posedge mclk); endclocking
	default disable iff (!rstn);
	property p_add_carry;
		go && op_code == OP_ADD_M |=> carry_r ==
			(({1'b0, $past(working_register)} + {1'b0, $past(mem_rdata)})
			> 9'h0ff);
	endproperty
	a_add_carry: assert property (p_add_carry) else $error("add carry");
	property p_one_cycle;
		go && op_code == OP_ADD_X |=> busy_r[*3] ##1 (done_r && !busy_r);
	endproperty
	a_one_cycle: assert property (p_one_cycle) else $error("add len");
	property p_adc;
		go && op_code == OP_ADC_M |=> working_register ==
			8'($past(working_register) + $past(mem_rdata) + $past(carry_r));
	endproperty
	a_adc: assert property (p_adc) else $error("adc sum");
	property p_add_mem;
		go && op_code == OP_ADD_TO_MEM |=> mem_we_r &&
			$stable(working_register) && mem_wdata_r ==
			8'($past(working_register) + $past(mem_rdata));
	endproperty
	a_add_mem: assert property (p_add_mem) else $error("add mem");
	property p_logic_flags;
		go && op_code inside {OP_AND_M, OP_OR_X, OP_XOR_TO_MEM} |=>
			$stable(carry_r) && $stable(signed_range_error) &&
			zero_r == (($past(to_mem) ? mem_wdata_r : working_register) == 0);
	endproperty
	a_logic_flags: assert property (p_logic_flags) else $error("logic");
	property p_set_bit;
		go && op_code == OP_SET_BIT |=> mem_we_r &&
			mem_wdata_r == ($past(mem_rdata) | (8'h01 << $past(op_bit)));
	endproperty
	a_set_bit: assert property (p_set_bit) else $error("set bit");
	property p_skip_len;
		go && op_code == OP_SKIP_ZERO && mem_rdata == 8'h00 |=>
			busy_r[*7] ##1 (done_r && skip_r);
	endproperty
	a_skip_len: assert property (p_skip_len) else $error("skip");
	property p_sector;
		take && bad_sector |=> err_r && !mem_we_r && !busy_r;
	endproperty
	a_sector: assert property (p_sector) else $error("sector");
	property p_rolc;
		go && op_code == OP_ROLC_TO_REG |=> carry_r == $past(mem_rdata[7])
			&& working_register == {$past(mem_rdata[6:0]), $past(carry_r)};
	endproperty
	a_rolc: assert property (p_rolc) else $error("rotate carry");
	c_call: cover property (go && op_code == OP_CALL ##8 push_r);
	c_skip: cover property (go && op_code == OP_SKIP_BIT_NZ ##8 skip_r);
	c_sub_mem: cover property (go && op_code == OP_SUBB_TO_MEM ##1 mem_we_r);
endmodule // mcuad_core

// [tb/mcuad_mem_model.sv]
/*
 * Sector-0 data memory model facing the execute stage.
 * Assumes write requests arrive as registered one-cycle pulses.
 */
`timescale 1ns/10ps
module mcuad_mem_model (
	// clock
	input wire logic mclk,
	// read side
	input wire logic op_valid,
	input wire logic [7:0] op_addr,
	output logic [7:0] mem_rdata,
	// write side
	input wire logic mem_we_r,
	input wire logic [7:0] mem_addr_r,
	input wire logic [7:0] mem_wdata_r
);
	logic [7:0] mem [256];
	// idle read shows the inverse, so a stale byte never passes
	assign mem_rdata = op_valid ? mem[op_addr] : ~mem[op_addr];
	// plain always: the bench preloads bytes from outside
	always @(posedge mclk) begin
		if (mem_we_r)
			mem[mem_addr_r] <= mem_wdata_r;
	end
endmodule // mcuad_mem_model

// [tb/mcu_alu_instruction_datapath_tb.sv]
/*
 * Self-checking bench for the execute-stage datapath.
 * Assumes the memory model answers reads in the request cycle.
 */
`timescale 1ns/10ps
module mcu_alu_instruction_datapath_tb import mcuad_pkg::*;;
	logic mclk = 1'b0;
	logic rst_b = 1'b0;
	logic op_valid = 1'b0;
	mcuad_op_t op_code = OP_NOP;
	logic [7:0] op_imm = 8'h00;
	logic [2:0] op_bit = 3'h0;
	logic [2:0] op_sector = 3'h0;
	logic [7:0] op_addr = 8'h00;
	logic [15:0] ret_addr = 16'h1234;
	logic [7:0] mem_rdata, mem_addr_r, mem_wdata_r, working_register, e;
	logic ready_r, done_r, err_r, mem_we_r, skip_r, jump_r, push_r, pop_r;
	logic zero_r, carry_r, nibble_carry_bit, signed_range_error;
	logic signed_carry_bit, chained_null_bit, er;
	logic [15:0] push_addr_r;
	logic [3:0] fl;
	int bad_count = 0;
	int samples_checked = 0;
	int cyc;
	mcuad_op_t sk_op [4] = '{OP_SKIP_ZERO, OP_SKIP_NZ, OP_SKIP_BIT_Z,
		OP_SKIP_BIT_NZ};
	mcuad_op_t fw_op [3] = '{OP_JUMP, OP_CALL, OP_RET};
	logic [3:0] fw_fl [3] = '{4'h4, 4'h6, 4'h1};
	wire [13:0] st = {working_register, zero_r, carry_r, nibble_carry_bit,
		signed_range_error, signed_carry_bit, chained_null_bit};

	mcuad_core uut (.*);
	mcuad_mem_model p (.*);

	// 250 MHz
	always #2 mclk = ~mclk;

	// one compare for every kind of result
	task automatic chk(string nm, logic [15:0] ex, logic [15:0] got);
		samples_checked++;
		if (got !== ex) begin
			bad_count++;
			$display("unexpected %s: expected %h, seen %h", nm, ex, got);
		end
	endtask

	task automatic finish_test();
		$display("mismatches %0d, comparisons %0d", bad_count,
			samples_checked);
		if (bad_count == 0 && samples_checked > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// request held until taken; cyc counts edges to done or refusal
	task automatic op(mcuad_op_t c, logic [7:0] a, logic [7:0] x,
		logic [2:0] b = 3'h0, logic [2:0] s = 3'h0);
		op_code = c;
		op_addr = a;
		op_imm = x;
		op_bit = b;
		op_sector = s;
		op_valid = 1'b1;
		cyc = 0;
		while (ready_r !== 1'b1 && cyc < 50) begin
			@(posedge mclk);
			#1;
			cyc++;
		end
		// the taking edge counts as the first clock of the instruction
		@(posedge mclk);
		#1;
		op_valid = 1'b0;
		cyc = 1;
		while (done_r !== 1'b1 && err_r !== 1'b1 && cyc < 20) begin
			@(posedge mclk);
			#1;
			cyc++;
		end
		fl = {skip_r, jump_r, push_r, pop_r};
		er = err_r;
	endtask

	// hang guard, far beyond the few hundred cycles needed
	initial begin
		#20000;
		bad_count++;
		finish_test();
	end

	initial begin
		{p.mem[8'h10], p.mem[8'h11], p.mem[8'h12], p.mem[8'h14]} = 32'he7180f0f;
		{p.mem[8'h15], p.mem[8'h16], p.mem[8'h17], p.mem[8'h18]} = 32'ha0ff0181;
		{p.mem[8'h19], p.mem[8'h06]} = 16'ha500;
		repeat (4) @(posedge mclk);
		#1;
		rst_b = 1'b1;
		chk("reset state", 14'h0, st);
		op(OP_ADD_X, 8'h00, 8'hc8);
		chk("add cycles", 4, cyc);
		chk("add state", {8'hc8, 6'b000010}, st);
		op(OP_ADD_X, 8'h00, 8'h50);
		chk("add carry", {8'h18, 6'b010000}, st);
		op(OP_ADC_TO_MEM, 8'h10, 8'h00);
		chk("adc state", {8'h18, 6'b111000}, st);
		chk("adc byte", 8'h00, p.mem[8'h10]);
		op(OP_SUB_M, 8'h11, 8'h00);
		chk("sub state", {8'h00, 6'b111001}, st);
		op(OP_SUBB_X, 8'h00, 8'h01);
		chk("sbb state", {8'hff, 6'b000010}, st);
		op(OP_SUBB_TO_MEM, 8'h12, 8'h00);
		chk("sbb mem state", {8'hff, 6'b010010}, st);
		chk("sbb byte", 8'hef, p.mem[8'h12]);
		op(OP_DEC_ADJ, 8'h13, 8'h00);
		chk("adjust byte", 8'h65, p.mem[8'h13]);
		chk("adjust state", {8'hff, 6'b010010}, st);
		op(OP_AND_X, 8'h00, 8'h0f);
		chk("and state", {8'h0f, 6'b010010}, st);
		op(OP_XOR_M, 8'h14, 8'h00);
		chk("xor state", {8'h00, 6'b110010}, st);
		op(OP_OR_TO_MEM, 8'h15, 8'h00);
		chk("or state", {8'h00, 6'b010010}, st);
		chk("or byte", 8'ha0, p.mem[8'h15]);
		op(OP_INV_TO_REG, 8'h16, 8'h00);
		chk("inv state", {8'h00, 6'b110010}, st);
		op(OP_INV, 8'h16, 8'h00);
		chk("inv byte", 8'h00, p.mem[8'h16]);
		op(OP_INC_TO_REG, 8'h16, 8'h00);
		chk("inc state", {8'h01, 6'b010010}, st);
		op(OP_DEC_TO_REG, 8'h17, 8'h00);
		chk("dec state", {8'h00, 6'b110010}, st);
		op(OP_ROL_TO_REG, 8'h18, 8'h00);
		chk("rol state", {8'h03, 6'b110010}, st);
		op(OP_ROR, 8'h18, 8'h00);
		chk("ror byte", 8'hc0, p.mem[8'h18]);
		op(OP_RORC_TO_REG, 8'h18, 8'h00);
		chk("rorc state", {8'he0, 6'b100010}, st);
		op(OP_ROLC, 8'h18, 8'h00);
		chk("rolc state", {8'he0, 6'b110010}, st);
		chk("rolc byte", 8'h80, p.mem[8'h18]);
		e = 8'ha5;
		// every bit set, then every bit cleared
		for (int i = 0; i < 16; i++) begin
			op(i < 8 ? OP_SET_BIT : OP_CLR_BIT, 8'h19, 8'h00, i[2:0]);
			e[i[2:0]] = i < 8;
			chk("bit byte", e, p.mem[8'h19]);
		end
		// byte is now zero: even entries skip, odd ones do not
		for (int i = 0; i < 4; i++) begin
			op(sk_op[i], 8'h19, 8'h00);
			chk("skip cycles", i[0] ? 4 : 8, cyc);
			chk("skip flow", i[0] ? 4'h0 : 4'h8, fl);
		end
		for (int i = 0; i < 3; i++) begin
			op(fw_op[i], 8'h00, 8'h00);
			chk("flow cycles", 8, cyc);
			chk("flow pulses", fw_fl[i], fl);
		end
		chk("return address", 16'h1234, push_addr_r);
		op(OP_ADD_TO_MEM, 8'h06, 8'h00);
		chk("pc low cycles", 8, cyc);
		chk("pc low jump", 4'h4, fl);
		chk("pc low byte", 8'he0, p.mem[8'h06]);
		op(OP_ADD_X, 8'h00, 8'h11, 3'h0, 3'h1);
		chk("refuse cycle", 1, cyc);
		chk("refuse pulse", 1'b1, er);
		chk("refuse state", {8'he0, 6'b000010}, st);
		// forms not reached above, chained on the state left behind
		op(OP_ADD_M, 8'h11, 8'h00);
		chk("add mem operand", {8'hf8, 6'b000010}, st);
		op(OP_ADC_M, 8'h12, 8'h00);
		chk("adc register", {8'he7, 6'b011010}, st);
		op(OP_ROLC_TO_REG, 8'h18, 8'h00);
		chk("rolc register", {8'h01, 6'b011010}, st);
		op(OP_SUB_X, 8'h00, 8'h01);
		chk("sub imm state", {8'h00, 6'b111001}, st);
		op(OP_SUBB_M, 8'h11, 8'h00);
		chk("sbb mem operand", {8'he8, 6'b000010}, st);
		op(OP_AND_M, 8'h14, 8'h00);
		chk("and mem state", {8'h08, 6'b000010}, st);
		op(OP_OR_X, 8'h00, 8'h70);
		chk("or imm state", {8'h78, 6'b000010}, st);
		op(OP_XOR_X, 8'h00, 8'h78);
		chk("xor imm state", {8'h00, 6'b100010}, st);
		op(OP_INC, 8'h17, 8'h00);
		chk("inc byte", 8'h02, p.mem[8'h17]);
		chk("inc mem state", {8'h00, 6'b000010}, st);
		op(OP_DEC, 8'h17, 8'h00);
		chk("dec byte", 8'h01, p.mem[8'h17]);
		op(OP_ROR_TO_REG, 8'h18, 8'h00);
		chk("ror register", {8'h40, 6'b000010}, st);
		op(OP_ROL, 8'h18, 8'h00);
		chk("rol byte", 8'h01, p.mem[8'h18]);
		finish_test();
	end
endmodule // mcu_alu_instruction_datapath_tb
